// File: chic_charger.v
/*
  Charger control: I2C two-byte command slave with one control/status
  register, and the trickle / constant-current / constant-voltage charge
  sequencer driven by comparator inputs.
  Assumes the comparators and the I2C pins are asynchronous to clock_i,
  and that the pads resolve open-drain levels from the enables.
*/
`timescale 1ns/10ps
`include "chic_map.vh"

module chic_charger #(
  parameter [6:0] DEV_ADDR = `CHIC_DEV_ADDR_DEF
) (
  input wire clock_i,
  input wire srst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire supply_above_bat_i,
  input wire supply_above_3v3_i,
  input wire temp_above_110_i,
  input wire temp_below_85_i,
  input wire bat_above_2v5_i,
  input wire bat_above_3v0_i,
  input wire bat_at_4v2_i,
  input wire bat_above_4v0_i,
  input wire cv_current_low_i,
  output reg charge_enable_o,
  output reg [2:0] charge_mode_o,
  output reg [10:0] selected_cc_current_o,
  output reg [19:0] charge_target_ua_o,
  output reg battery_divider_enable_o,
  output reg supply_presence_out_o,
  output reg supply_presence_oe_o,
  output reg i2c_awake_o
);
  wire scl_s;
  wire sda_s;
  wire sup_ok_s;
  wire sup_3v3_s;
  wire t_hi_s;
  wire t_lo_s;
  wire b_2v5_s;
  wire b_3v0_s;
  wire b_4v2_s;
  wire b_4v0_s;
  wire i_low_s;
  wire [10:0] async_in;
  wire [10:0] sync_out;

  assign async_in = {scl_i, sda_i, supply_above_bat_i, supply_above_3v3_i,
    temp_above_110_i, temp_below_85_i, bat_above_2v5_i, bat_above_3v0_i,
    bat_at_4v2_i, bat_above_4v0_i, cv_current_low_i};
  assign {scl_s, sda_s, sup_ok_s, sup_3v3_s, t_hi_s, t_lo_s, b_2v5_s, b_3v0_s,
    b_4v2_s, b_4v0_s, i_low_s} = sync_out;

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
      chic_sync u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .async_i(async_in[gi]),
        .sync_o(sync_out[gi])
      );
    end
  endgenerate

  // Selected constant current in mA
  function [10:0] sel_to_ma;
    input [3:0] sel;
    begin
      if (sel <= `CHIC_MA_CODE_LOW)
        sel_to_ma = `CHIC_MA_MIN;
      else if (sel <= `CHIC_SEL_LAST_STEP50)
        sel_to_ma = `CHIC_MA_STEP50 * {7'h00, sel};
      else
        sel_to_ma = `CHIC_MA_AT_400 +
          `CHIC_MA_STEP100 * {7'h00, sel - `CHIC_SEL_LAST_STEP50};
    end
  endfunction

  // Register and status
  reg [7:0] ctrl;
  reg over_temp;
  reg stopped;
  reg [2:0] cstate;
  reg [2:0] next_cstate;
  wire [7:0] reg_view;
  assign reg_view = {sup_ok_s, stopped, over_temp, ctrl[`CHIC_BIT_DIV_EN],
    ctrl[`CHIC_SEL_MSB:0]};

  always @(posedge clock_i) begin
    if (srst_i)
      over_temp <= 1'b0;
    else if (t_hi_s)
      over_temp <= 1'b1;
    else if (t_lo_s)
      over_temp <= 1'b0;
  end

  // Charge sequencer
  wire sel_dis;
  assign sel_dis = (ctrl[`CHIC_SEL_MSB:0] == `CHIC_SEL_DISABLE);

  always @* begin
    next_cstate = cstate;
    if (!sup_ok_s || sel_dis) begin
      next_cstate = `CHIC_ST_IDLE;
    end else begin
      case (cstate)
        `CHIC_ST_IDLE: begin
          if (b_4v2_s)
            next_cstate = `CHIC_ST_CV;
          else if (b_3v0_s)
            next_cstate = `CHIC_ST_CC;
          else
            next_cstate = `CHIC_ST_TRICKLE;
        end
        `CHIC_ST_TRICKLE: begin
          if (b_3v0_s)
            next_cstate = `CHIC_ST_CC;
        end
        `CHIC_ST_CC: begin
          if (b_4v2_s)
            next_cstate = `CHIC_ST_CV;
          else if (!b_3v0_s)
            next_cstate = `CHIC_ST_TRICKLE;
        end
        `CHIC_ST_CV: begin
          if (i_low_s)
            next_cstate = `CHIC_ST_DONE;
        end
        `CHIC_ST_DONE: begin
          if (!b_4v0_s)
            next_cstate = `CHIC_ST_IDLE;
        end
        default: next_cstate = `CHIC_ST_IDLE;
      endcase
    end
  end

  wire [10:0] cc_ma;
  assign cc_ma = sel_to_ma(ctrl[`CHIC_SEL_MSB:0]);
  wire [19:0] cc_ua;
  assign cc_ua = `CHIC_UA_PER_MA * {9'h000, cc_ma};

  always @(posedge clock_i) begin
    if (srst_i) begin
      cstate <= `CHIC_ST_IDLE;
      stopped <= 1'b0;
      charge_enable_o <= 1'b0;
      charge_mode_o <= `CHIC_ST_IDLE;
      selected_cc_current_o <= `CHIC_MA_MIN;
      charge_target_ua_o <= 20'h00000;
      battery_divider_enable_o <= 1'b0;
      supply_presence_out_o <= 1'b0;
      supply_presence_oe_o <= 1'b0;
    end else begin
      cstate <= next_cstate;
      stopped <= (next_cstate == `CHIC_ST_DONE) ||
        (next_cstate == `CHIC_ST_IDLE && cstate != `CHIC_ST_IDLE) ||
        (stopped && next_cstate == `CHIC_ST_IDLE);
      charge_enable_o <= (next_cstate != `CHIC_ST_IDLE) &&
        (next_cstate != `CHIC_ST_DONE);
      charge_mode_o <= next_cstate;
      selected_cc_current_o <= cc_ma;
      case (next_cstate)
        `CHIC_ST_TRICKLE:
          charge_target_ua_o <= b_2v5_s ? (cc_ua / `CHIC_TRICKLE_DIV)
            : `CHIC_PRE_CURRENT_UA;
        `CHIC_ST_CC: charge_target_ua_o <= cc_ua;
        `CHIC_ST_CV: charge_target_ua_o <= cc_ua;
        default: charge_target_ua_o <= 20'h00000;
      endcase
      battery_divider_enable_o <= ctrl[`CHIC_BIT_DIV_EN];
      supply_presence_out_o <= 1'b0;
      supply_presence_oe_o <= sup_3v3_s;
    end
  end

  // I2C slave
  reg scl_d;
  reg sda_d;
  reg [2:0] istate;
  reg [2:0] ret_state;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] cmd;
  reg rd_dir;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;

  always @(posedge clock_i) begin
    if (srst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      istate <= `CHIC_I2C_SLEEP;
      ret_state <= `CHIC_I2C_SLEEP;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      rd_dir <= 1'b0;
      ctrl <= `CHIC_REG_RESET;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      i2c_awake_o <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      i2c_awake_o <= (istate != `CHIC_I2C_SLEEP);
      if (stop_c) begin
        istate <= `CHIC_I2C_SLEEP;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        istate <= `CHIC_I2C_ADDR;
        bitcnt <= 3'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (istate)
          `CHIC_I2C_SLEEP: sda_oe_o <= 1'b0;
          `CHIC_I2C_ADDR, `CHIC_I2C_CMD, `CHIC_I2C_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == `CHIC_BYTE_LAST) begin
                ret_state <= istate;
                istate <= `CHIC_I2C_ACK;
              end
            end
          end
          `CHIC_I2C_ACK: begin
            if (scl_fall && !sda_oe_o) begin
              if (ret_state == `CHIC_I2C_ADDR && shreg[7:1] != DEV_ADDR) begin
                istate <= `CHIC_I2C_DONE;
              end else if (ret_state == `CHIC_I2C_ADDR) begin
                rd_dir <= shreg[0];
                sda_o <= 1'b0;
                sda_oe_o <= 1'b1;
              end else begin
                if (ret_state == `CHIC_I2C_CMD)
                  cmd <= shreg;
                if (ret_state == `CHIC_I2C_WDATA && cmd == `CHIC_CMD_WRITE)
                  ctrl <= (ctrl & ~`CHIC_WR_MASK) |
                    (shreg & `CHIC_WR_MASK);
                sda_o <= 1'b0;
                sda_oe_o <= 1'b1;
              end
            end else if (scl_fall && sda_oe_o) begin
              sda_oe_o <= 1'b0;
              bitcnt <= 3'h0;
              if (ret_state == `CHIC_I2C_ADDR && rd_dir &&
                  cmd == `CHIC_CMD_READ) begin
                shreg <= {reg_view[6:0], 1'b0};
                sda_o <= reg_view[7];
                sda_oe_o <= !reg_view[7];
                istate <= `CHIC_I2C_RDATA;
              end else if (ret_state == `CHIC_I2C_ADDR)
                istate <= rd_dir ? `CHIC_I2C_DONE : `CHIC_I2C_CMD;
              else if (ret_state == `CHIC_I2C_CMD)
                istate <= (cmd == `CHIC_CMD_WRITE) ? `CHIC_I2C_WDATA
                  : `CHIC_I2C_DONE;
              else
                istate <= `CHIC_I2C_DONE;
            end
          end
          `CHIC_I2C_RDATA: begin
            if (scl_fall) begin
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == `CHIC_BYTE_LAST) begin
                sda_oe_o <= 1'b0;
                istate <= `CHIC_I2C_DONE;
              end else begin
                sda_o <= shreg[7];
                sda_oe_o <= !shreg[7];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          `CHIC_I2C_DONE: sda_oe_o <= 1'b0;
          default: istate <= `CHIC_I2C_SLEEP;
        endcase
      end
    end
  end
endmodule

// File: chic_map.vh
/*
  Constants for the charger control block: I2C command codes, register
  field positions, reset value, charge-current codes and state encodings.
  Assumes inclusion by the charger control design files only.
*/
`ifndef CHIC_MAP_VH
`define CHIC_MAP_VH

`define CHIC_CMD_WRITE 8'h01
`define CHIC_CMD_READ 8'h51
`define CHIC_REG_RESET 8'h00
`define CHIC_BIT_SUPPLY_OK 7
`define CHIC_BIT_STOPPED 6
`define CHIC_BIT_OVER_TEMP 5
`define CHIC_BIT_DIV_EN 4
`define CHIC_SEL_MSB 3
`define CHIC_WR_MASK 8'h1F
`define CHIC_SEL_DISABLE 4'hF
`define CHIC_SEL_LAST_STEP50 4'h8
`define CHIC_MA_MIN 11'h064
`define CHIC_MA_STEP50 11'h032
`define CHIC_MA_STEP100 11'h064
`define CHIC_MA_AT_400 11'h190
`define CHIC_MA_CODE_LOW 4'h2
`define CHIC_TRICKLE_DIV 11'h00C
`define CHIC_PRE_CURRENT_UA 20'h0206C
`define CHIC_UA_PER_MA 20'h003E8

`define CHIC_ST_IDLE 3'h0
`define CHIC_ST_TRICKLE 3'h1
`define CHIC_ST_CC 3'h2
`define CHIC_ST_CV 3'h3
`define CHIC_ST_DONE 3'h4

`define CHIC_I2C_SLEEP 3'h0
`define CHIC_I2C_ADDR 3'h1
`define CHIC_I2C_CMD 3'h2
`define CHIC_I2C_WDATA 3'h3
`define CHIC_I2C_RDATA 3'h4
`define CHIC_I2C_ACK 3'h5
`define CHIC_I2C_DONE 3'h6

`define CHIC_BYTE_LAST 3'h7
`define CHIC_DEV_ADDR_DEF 7'h2A

`endif

// File: chic_sync.v
/*
  Two-flip-flop synchroniser for one asynchronous level.
  Assumes the input is from outside the clock_i domain.
*/
`timescale 1ns/10ps
module chic_sync (
  input wire clock_i,
  input wire srst_i,
  input wire async_i,
  output reg sync_o
);
  reg meta;

  always @(posedge clock_i) begin
    if (srst_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// File: chic_charger_assertions.sv
/*
  Port checker for the charger control block.
  Assumes it is bound onto chic_charger and sees only its ports.
*/
`timescale 1ns/10ps
module chic_checker (
  input wire clock_i,
  input wire srst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire supply_above_bat_i,
  input wire supply_above_3v3_i,
  input wire bat_above_2v5_i,
  input wire charge_enable_o,
  input wire [2:0] charge_mode_o,
  input wire [10:0] selected_cc_current_o,
  input wire [19:0] charge_target_ua_o,
  input wire supply_presence_out_o,
  input wire supply_presence_oe_o,
  input wire i2c_awake_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  a_reset_clears:
    assert property ($fell(srst_i) |-> charge_mode_o == 3'h0 && !i2c_awake_o
      && selected_cc_current_o == 11'h064) else $error("state not cleared by reset");
  a_presence_low:
    assert property (supply_presence_oe_o |-> !supply_presence_out_o)
      else $error("presence pin driven high");
  a_presence_follow:
    assert property ($stable(supply_above_3v3_i) [*6] |->
      supply_presence_oe_o == supply_above_3v3_i) else $error("presence enable wrong");
  a_supply_gate:
    assert property ((!supply_above_bat_i) [*8] |-> !charge_enable_o)
      else $error("charging without supply");
  a_enable_mode:
    assert property (charge_enable_o == (charge_mode_o inside {3'h1, 3'h2, 3'h3}))
      else $error("enable and mode disagree");
  a_trickle_target:
    assert property ((!bat_above_2v5_i) [*8] ##0 (charge_mode_o == 3'h1) [*2] |->
      charge_target_ua_o == 20'h0206C) else $error("precharge current wrong");
  a_wake_start:
    assert property (scl_i && $fell(sda_i) |-> ##[2:8] i2c_awake_o)
      else $error("no wake on start");
  a_sleep_stop:
    assert property (scl_i && $rose(sda_i) |-> ##[2:8] !i2c_awake_o)
      else $error("no sleep after stop");
  a_quiet_asleep:
    assert property (sda_oe_o |-> !sda_o && i2c_awake_o)
      else $error("data line driven while asleep");
endmodule

// File: chic_host.sv
/*
  I2C host model: open-drain data, 32 ns clock only within frames.
  Assumes the bench resolves the data line from both parties with a pull-up.
*/
`timescale 1ns/10ps
module chic_host (
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o,
  output reg [11:0] res_o,
  output reg done_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    res_o = 12'h000;
    done_o = 1'b0;
  end
  task start;
    begin
      sda_low_o = 1'b0;
      #8 scl_o = 1'b1;
      #8 sda_low_o = 1'b1;
      #8 scl_o = 1'b0;
      #8;
    end
  endtask
  task bit_io(input b, output s);
    begin
      sda_low_o = !b;
      #8 scl_o = 1'b1;
      #8 s = sda_i;
      #8 scl_o = 1'b0;
      #8;
    end
  endtask
  // Ninth bit released: reads device acknowledge, or sends not-acknowledge
  task xfer(input [7:0] tx, output [7:0] rx, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(tx[i], s);
        rx[i] = s;
      end
      bit_io(1'b1, s);
      ack = !s;
    end
  endtask
  task txn(input [6:0] a, input [7:0] c, input [7:0] d, input rd);
    reg [3:0] k;
    reg [7:0] q;
    reg [7:0] x;
    begin
      q = 8'h00;
      k = 4'h0;
      start;
      xfer({a, 1'b0}, x, k[3]);
      xfer(c, x, k[2]);
      if (rd) begin
        start;
        xfer({a, 1'b1}, x, k[1]);
        xfer(8'hFF, q, k[0]);
      end else begin
        xfer(d, x, k[1]);
      end
      sda_low_o = 1'b1;
      #8 scl_o = 1'b1;
      #8 sda_low_o = 1'b0;
      #16 res_o = {k, q};
      done_o = 1'b1;
      #2 done_o = 1'b0;
    end
  endtask
endmodule

// File: tb_top.sv
/*
  Bench for the charger control block: host model, comparators, checks.
  Assumes chic_charger, chic_host and chic_checker are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  reg clock_i = 1'b0;
  reg srst_i = 1'b1;
  reg supply_above_bat_i = 0, supply_above_3v3_i = 0, temp_above_110_i = 0;
  reg temp_below_85_i = 0, bat_above_2v5_i = 0, bat_above_3v0_i = 0;
  reg bat_at_4v2_i = 0, bat_above_4v0_i = 0, cv_current_low_i = 0;
  wire scl_i, sda_i, sda_o, sda_oe_o, host_low, done, charge_enable_o;
  wire battery_divider_enable_o, supply_presence_out_o, supply_presence_oe_o, i2c_awake_o;
  wire [2:0] charge_mode_o;
  wire [10:0] selected_cc_current_o;
  wire [19:0] charge_target_ua_o;
  wire [11:0] res;
  integer mismatches = 0;
  integer tests_run = 0;
  integer c;
  reg [11:0] exp_q[$];
  reg [31:0] r;
  assign sda_i = !(host_low || (sda_oe_o && !sda_o));
  chic_charger dut (
    .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .supply_above_bat_i(supply_above_bat_i),
    .supply_above_3v3_i(supply_above_3v3_i), .temp_above_110_i(temp_above_110_i),
    .temp_below_85_i(temp_below_85_i), .bat_above_2v5_i(bat_above_2v5_i),
    .bat_above_3v0_i(bat_above_3v0_i), .bat_at_4v2_i(bat_at_4v2_i),
    .bat_above_4v0_i(bat_above_4v0_i), .cv_current_low_i(cv_current_low_i),
    .charge_enable_o(charge_enable_o), .charge_mode_o(charge_mode_o),
    .selected_cc_current_o(selected_cc_current_o), .charge_target_ua_o(charge_target_ua_o),
    .battery_divider_enable_o(battery_divider_enable_o),
    .supply_presence_out_o(supply_presence_out_o),
    .supply_presence_oe_o(supply_presence_oe_o), .i2c_awake_o(i2c_awake_o)
  );
  chic_host host (.sda_i(sda_i), .scl_o(scl_i), .sda_low_o(host_low), .res_o(res),
    .done_o(done));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic check(input [19:0] seen, input [19:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task op(input [6:0] a, input [7:0] cm, input [7:0] d, input rd, input [11:0] e);
    begin
      exp_q.push_back(e);
      host.txn(a, cm, d, rd);
    end
  endtask
  // Comparator order: cv_low 4v0 4v2 3v0 2v5 t85 t110 3v3 supply
  task settle(input [8:0] v, input [2:0] m);
    begin
      @(posedge clock_i);
      #1;
      {cv_current_low_i, bat_above_4v0_i, bat_at_4v2_i, bat_above_3v0_i, bat_above_2v5_i,
        temp_below_85_i, temp_above_110_i, supply_above_3v3_i, supply_above_bat_i} = v;
      repeat (12) @(posedge clock_i);
      #1;
      check(charge_mode_o, m);
    end
  endtask
  function [10:0] ma_of(input [3:0] s);
    ma_of = s < 4'h3 ? 11'h064 : s <= 4'h8 ? 11'h032 * s : 11'h190 + 11'h064 * (s - 4'h8);
  endfunction
  always @(posedge done) begin
    if (exp_q.size() == 0) begin
      check(res, 20'h03FFF);
    end else begin
      check(res, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    r = $urandom(62179);
    repeat (16) @(posedge clock_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    check(selected_cc_current_o, 11'h064);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hE00);
    op(7'h2B, 8'h01, 8'h1F, 1'b0, 12'h000);
    op(7'h2A, 8'h22, 8'h1F, 1'b0, 12'hC00);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hE00);
    check(i2c_awake_o, 1'b0);
    for (c = 0; c < 15; c = c + 1) begin
      r = $urandom;
      op(7'h2A, 8'h01, {r[7:4], c[3:0]}, 1'b0, 12'hE00);
      op(7'h2A, 8'h51, 8'h00, 1'b1, {4'hE, 3'h0, r[4], c[3:0]});
      check(selected_cc_current_o, ma_of(c[3:0]));
      check(battery_divider_enable_o, r[4]);
    end
    op(7'h2A, 8'h01, 8'h04, 1'b0, 12'hE00);
    settle(9'h003, 3'h1);
    check(charge_target_ua_o, 20'h0206C);
    check(supply_presence_oe_o, 1'b1);
    settle(9'h013, 3'h1);
    check(charge_target_ua_o, 20'h0411A);
    settle(9'h033, 3'h2);
    check(charge_target_ua_o, 20'h30D40);
    check(selected_cc_current_o, 11'h0C8);
    settle(9'h0F3, 3'h3);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hE84);
    settle(9'h1F3, 3'h4);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hEC4);
    settle(9'h033, 3'h2);
    op(7'h2A, 8'h01, 8'h0F, 1'b0, 12'hE00);
    settle(9'h033, 3'h0);
    settle(9'h037, 3'h0);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hEEF);
    settle(9'h033, 3'h0);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hEEF);
    settle(9'h03A, 3'h0);
    op(7'h2A, 8'h51, 8'h00, 1'b1, 12'hE4F);
    check(exp_q.size(), 20'h00000);
    give_verdict;
  end
endmodule
bind chic_charger chic_checker chk (
  .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .supply_above_bat_i(supply_above_bat_i),
  .supply_above_3v3_i(supply_above_3v3_i), .bat_above_2v5_i(bat_above_2v5_i),
  .charge_enable_o(charge_enable_o), .charge_mode_o(charge_mode_o),
  .selected_cc_current_o(selected_cc_current_o), .charge_target_ua_o(charge_target_ua_o),
  .supply_presence_out_o(supply_presence_out_o),
  .supply_presence_oe_o(supply_presence_oe_o), .i2c_awake_o(i2c_awake_o)
);
